// ---- hdl/dmwc_ctl.sv ----
// Direct-mapped write-through cache controller
//
// Operation
// RULE1: Low 13 address bits index tags and data
// RULE2: Tag is upper 11 address bits
// RULE3: Five constant one bits mark valid entries
// RULE4: Hit only when every slice matches
// RULE5: Hit gives cache data; miss waits memory
// RULE6: One pulse clears all tags at power-up
// RULE7: Read miss fills data and tag together
// RULE8: Read hit returns cache data, no memory
// RULE9: Same index, other tag is a miss
// RULE10: Every write goes to memory and cache; code skips the cache on forced misses and byte misses
// RULE11: Byte writes update cache only on hit
// RULE12: Unbuffered writes wait full memory cycle
// RULE13: Optional buffered write overlaps memory write
// RULE14: Strobe is request delayed by match time
// RULE15: Processor cycle 50 ns, hit within 100
// RULE16: Strobe triggers cache write from memory cycles
// RULE17: Match latched by strobe, held during write
// RULE18: I/O addresses always forced to miss
// RULE19: DMA writes snooped, else buffers uncached
// RULE20: Tag slices are 8 bits with comparator
// RULE21: Tag clear also issued on system reset
// RULE22: Miss holds wait until memory completes
// RULE23: Forced miss suppresses cache refill write
`timescale 1ns/1ns

module dmwc_ctl
	import dmwc_pkg::*;
(
	input  wire logic                     mclk,
	input  wire logic                     reset_n,
	input  wire logic                     sys_clear,
	input  wire logic                     buf_wr_en,
	input  wire logic                     snoop_en,
	input  wire logic                     cpu_req,
	input  wire dmwc_cmd_t                cpu_cmd,
	output logic [`DMWC_DATA_W-1:0]       cpu_rdata,
	output logic                          cpu_match,
	output logic                          cpu_done,
	input  wire logic                     dma_wr,
	input  wire dmwc_cmd_t                dma_cmd,
	output logic                          dma_done,
	output logic                          mem_req,
	output dmwc_cmd_t                     mem_cmd,
	input  wire logic                     mem_done,
	input  wire logic [`DMWC_DATA_W-1:0]  mem_rdata,
	output logic                          tag_clear
);

	localparam int SLICE_W = `DMWC_SLICE_W;
	localparam logic [`DMWC_CNT_W-1:0] STROBE_LAST =
		`DMWC_CNT_W'(`DMWC_STROBE_CYC - 1);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	dmwc_state_t                       state;
	dmwc_cmd_t                         cur;
	logic                              cur_dma;
	logic [`DMWC_CNT_W-1:0]            dly;
	logic                              init_pend;
	logic [`DMWC_DATA_W-1:0]           dstore [`DMWC_DEPTH];
	logic [`DMWC_DATA_W-1:0]           data_q;

	logic [`DMWC_IDX_W-1:0]            index;
	logic [`DMWC_DATA_W-1:0]           tag_word;
	logic [`DMWC_SLICES-1:0]           slice_match;
	logic                              match_all;
	logic                              forced;
	logic [3:0]                        region;
	logic                              io_addr;
	logic                              dma_buf;
	logic                              hit_eff;
	logic                              at_strobe;
	logic                              full_word;
	logic                              need_mem;
	logic                              stall;
	logic                              start_mem;
	logic                              wr_upd;
	logic                              fill;
	logic                              data_we;
	logic                              tag_we;
	logic [`DMWC_DATA_W-1:0]           merged;
	logic [`DMWC_DATA_W-1:0]           data_wdata;

	// ------------------------------------------------------------------
	// Address split and tag word
	// ------------------------------------------------------------------
	// RULE1: index from low bits
	assign index = cur.addr[`DMWC_IDX_W-1:0];

	// RULE2: upper address as tag
	// RULE3: constant valid ones
	assign tag_word = {`DMWC_VALID_ONES, cur.addr[`DMWC_TAG_MSB:`DMWC_TAG_LSB]};

	// ------------------------------------------------------------------
	// Tag slices
	// ------------------------------------------------------------------
	// RULE20: 8-bit compare slices
	for (genvar s = 0; s < `DMWC_SLICES; s++) begin : g_slice
		dmwc_tag_slice u_slice (
			.mclk    (mclk),
			.reset_n (reset_n),
			.clear   (tag_clear),
			.index   (index),
			.we      (tag_we),
			.wdata   (tag_word[s*SLICE_W +: SLICE_W]),
			.cmp     (tag_word[s*SLICE_W +: SLICE_W]),
			.match   (slice_match[s])
		);
	end

	// RULE4: wired-AND of slices
	// RULE9: differing upper bits miss
	assign match_all = &slice_match;

	// ------------------------------------------------------------------
	// Uncached regions
	// ------------------------------------------------------------------
	assign region  = cur.addr[`DMWC_REGION_MSB:`DMWC_REGION_LSB];

	// RULE18: I/O region forced miss
	assign io_addr = (region == `DMWC_IO_REGION);

	// RULE19: DMA buffers uncached without snoop
	// A buffer copy would go stale behind an unsnooped DMA write
	assign dma_buf = !snoop_en && (region == `DMWC_DMA_REGION);

	assign forced  = io_addr | dma_buf;

	assign hit_eff   = match_all & ~forced;
	assign full_word = (cur.be == `DMWC_BE_FULL);

	// ------------------------------------------------------------------
	// Decision at the timing strobe
	// ------------------------------------------------------------------
	// RULE14: strobe after match delay
	assign at_strobe = (state == DMWC_STROBE) && (dly == STROBE_LAST);

	// Reads that hit and snooped DMA never touch main memory
	assign need_mem  = !cur_dma && (cur.we || !hit_eff);
	// A buffered write still in flight holds off the next memory access
	assign stall     = at_strobe && need_mem && mem_req;
	assign start_mem = at_strobe && need_mem && !mem_req;

	// RULE10: write also into cache
	// RULE11: bytes only on hit
	// RULE19: snoop updates matching entry
	assign wr_upd = at_strobe && !stall && cur.we && !forced &&
		(cur_dma ? (snoop_en && match_all) : (full_word || hit_eff));

	// RULE23: no refill on forced miss
	assign fill = (state == DMWC_FILL);

	assign data_we = wr_upd || fill;
	// Snoops never retag: only an entry that already matched is touched
	assign tag_we  = fill || (wr_upd && !cur_dma && full_word);

	always_comb begin
		merged = data_q;
		if (cur.be[0]) begin
			merged[7:0] = cur.data[7:0];
		end
		if (cur.be[1]) begin
			merged[15:8] = cur.data[15:8];
		end
	end

	// Word writes store the new word whole, whatever the old entry held
	assign data_wdata = fill ? cpu_rdata : merged;

	// ------------------------------------------------------------------
	// Data store
	// ------------------------------------------------------------------
	// RULE7: data written at index
	// RULE16: strobe-driven cache write
	always_ff @(posedge mclk) begin
		if (data_we) begin
			dstore[index] <= data_wdata;
		end
	end

	// Registered read keeps the store a plain synchronous RAM
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			data_q <= '0;
		end else begin
			data_q <= dstore[index];
		end
	end

	// ------------------------------------------------------------------
	// Tag clear
	// ------------------------------------------------------------------
	// RULE6: single clear pulse at start
	// RULE21: clear on system reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			init_pend <= 1'b1;
			tag_clear <= 1'b0;
		end else begin
			init_pend <= 1'b0;
			tag_clear <= init_pend | sys_clear;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state   <= DMWC_IDLE;
			cur     <= '0;
			cur_dma <= 1'b0;
			dly     <= '0;
		end else begin
			case (state)
				DMWC_IDLE: begin
					dly <= '0;
					// Nothing is taken while the tags are being cleared
					if (init_pend || tag_clear || sys_clear) begin
						state <= DMWC_IDLE;
					end else if (dma_wr) begin
						cur     <= dma_cmd;
						cur_dma <= 1'b1;
						state   <= DMWC_STROBE;
					end else if (cpu_req) begin
						cur     <= cpu_cmd;
						cur_dma <= 1'b0;
						state   <= DMWC_STROBE;
					end
				end
				DMWC_STROBE: begin
					dly <= dly + 1'b1;
					if (at_strobe) begin
						dly <= '0;
						if (stall) begin
							state <= DMWC_DRAIN;
						end else if (!need_mem) begin
							state <= DMWC_IDLE;
						end else if (cur.we && buf_wr_en) begin
							// RULE13: release before memory ends
							state <= DMWC_IDLE;
						end else begin
							// RULE12: unbuffered write waits memory
							state <= DMWC_MEM;
						end
					end
				end
				DMWC_DRAIN: begin
					// Re-run the strobe so the match is fresh after the wait
					if (!mem_req) begin
						state <= DMWC_STROBE;
					end
				end
				DMWC_MEM: begin
					// RULE22: wait for memory completion
					if (mem_done) begin
						// RULE23: forced reads are not refilled
						if (!cur.we && !forced) begin
							state <= DMWC_FILL;
						end else begin
							state <= DMWC_IDLE;
						end
					end
				end
				DMWC_FILL: begin
					state <= DMWC_IDLE;
				end
				default: begin
					state <= DMWC_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Main memory port
	// ------------------------------------------------------------------
	// The captured command doubles as the write buffer in buffered mode
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mem_req <= 1'b0;
			mem_cmd <= '0;
		end else if (start_mem) begin
			mem_req <= 1'b1;
			mem_cmd <= cur;
		end else if (mem_done) begin
			mem_req <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Processor answer
	// ------------------------------------------------------------------
	// RULE17: match latched at strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_match <= 1'b0;
		end else if (at_strobe && !stall && !cur_dma) begin
			cpu_match <= hit_eff;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_rdata <= '0;
		end else if (at_strobe && !stall && !cur_dma && !cur.we && hit_eff) begin
			// RULE8: hit data from cache
			cpu_rdata <= data_q;
		end else if (state == DMWC_MEM && mem_done && !cur.we) begin
			// RULE5: miss data from memory
			cpu_rdata <= mem_rdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_done <= 1'b0;
		end else begin
			cpu_done <= 1'b0;
			if (at_strobe && !stall && !cur_dma &&
			    (!need_mem || (cur.we && buf_wr_en))) begin
				cpu_done <= 1'b1;
			end else if (state == DMWC_MEM && mem_done && (cur.we || forced)) begin
				cpu_done <= 1'b1;
			end else if (fill) begin
				cpu_done <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// DMA answer
	// ------------------------------------------------------------------
	// A snoop never waits for main memory: the DMA master writes it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dma_done <= 1'b0;
		end else begin
			dma_done <= at_strobe && cur_dma;
		end
	end

endmodule

// ---- hdl/dmwc_tag_slice.sv ----
// One 8-bit tag slice: storage, bulk clear and equality compare
`timescale 1ns/1ns

module dmwc_tag_slice
	import dmwc_pkg::*;
(
	input  wire logic                     mclk,
	input  wire logic                     reset_n,
	input  wire logic                     clear,
	input  wire logic [`DMWC_IDX_W-1:0]   index,
	input  wire logic                     we,
	input  wire logic [`DMWC_SLICE_W-1:0] wdata,
	input  wire logic [`DMWC_SLICE_W-1:0] cmp,
	output logic                          match
);

	logic [`DMWC_SLICE_W-1:0] mem [`DMWC_DEPTH];
	logic [`DMWC_SLICE_W-1:0] rd;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// Clear wins over a write so a clear pulse always leaves all zeros
	always_ff @(posedge mclk) begin
		if (clear) begin
			for (int i = 0; i < `DMWC_DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (we) begin
			mem[index] <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd <= '0;
		end else begin
			rd <= mem[index];
		end
	end

	// ------------------------------------------------------------------
	// Compare
	// ------------------------------------------------------------------
	assign match = (rd == cmp);

endmodule

// ---- inc/dmwc_params.svh ----
// Constants of the direct-mapped write-through cache controller
`ifndef DMWC_PARAMS_SVH
`define DMWC_PARAMS_SVH

// ------------------------------------------------------------------
// Widths
// ------------------------------------------------------------------
`define DMWC_ADDR_W     24
`define DMWC_DATA_W     16
`define DMWC_IDX_W      13
`define DMWC_TAG_W      11
`define DMWC_VALID_W    5
`define DMWC_SLICE_W    8
`define DMWC_SLICES     2
`define DMWC_DEPTH      8192
`define DMWC_BE_W       2

// ------------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------------
`define DMWC_TAG_LSB    13
`define DMWC_TAG_MSB    23
`define DMWC_VALID_ONES 5'h1F
`define DMWC_BE_FULL    2'h3
`define DMWC_REGION_MSB 23
`define DMWC_REGION_LSB 20
`define DMWC_IO_REGION  4'hF
`define DMWC_DMA_REGION 4'hE

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define DMWC_CLK_NS     4
`define DMWC_MATCH_NS   37
`define DMWC_STROBE_CYC ((`DMWC_MATCH_NS + `DMWC_CLK_NS - 1) / `DMWC_CLK_NS)
`define DMWC_CNT_W      4

`endif

// ---- inc/dmwc_pkg.sv ----
// Types of the direct-mapped write-through cache controller
`include "dmwc_params.svh"

package dmwc_pkg;

	typedef struct packed {
		logic                    we;
		logic [`DMWC_BE_W-1:0]   be;
		logic [`DMWC_ADDR_W-1:0] addr;
		logic [`DMWC_DATA_W-1:0] data;
	} dmwc_cmd_t;

	typedef enum logic [2:0] {
		DMWC_IDLE,
		DMWC_STROBE,
		DMWC_DRAIN,
		DMWC_MEM,
		DMWC_FILL
	} dmwc_state_t;

endpackage

// ---- testbench/dmwc_ctl_checker.sv ----
// Port assertions for the cache controller
`timescale 1ns/1ns
`include "dmwc_params.svh"

module dmwc_ctl_checker
	import dmwc_pkg::*;
(
	input wire logic                    mclk,
	input wire logic                    reset_n,
	input wire logic                    sys_clear,
	input wire logic                    buf_wr_en,
	input wire logic                    cpu_done,
	input wire logic                    cpu_match,
	input wire logic [`DMWC_DATA_W-1:0] cpu_rdata,
	input wire logic                    dma_done,
	input wire logic                    mem_req,
	input wire dmwc_cmd_t               mem_cmd,
	input wire logic                    mem_done,
	input wire logic [`DMWC_DATA_W-1:0] mem_rdata,
	input wire logic                    tag_clear
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_init;
		reset_n && !$past(reset_n) |=> tag_clear;
	endproperty
	a_init: assert property (p_init) else $error("no tag clear after reset");
	property p_clr;
		sys_clear |-> ##[0:2] tag_clear;
	endproperty
	a_clr: assert property (p_clr) else $error("no tag clear on request");
	property p_hold;
		mem_req && !mem_done |=> mem_req && $stable(mem_cmd);
	endproperty
	a_hold: assert property (p_hold) else $error("memory request dropped early");
	property p_drop;
		mem_req && mem_done |=> !mem_req;
	endproperty
	a_drop: assert property (p_drop) else $error("memory request held too long");
	property p_rdmiss;
		mem_req && !mem_cmd.we |-> !cpu_match;
	endproperty
	a_rdmiss: assert property (p_rdmiss) else $error("memory read on a hit");
	property p_rddone;
		mem_req && mem_done && !mem_cmd.we |-> ##[1:2] cpu_done;
	endproperty
	a_rddone: assert property (p_rddone) else $error("read not released");
	property p_rdata;
		mem_req && mem_done && !mem_cmd.we |=> cpu_rdata == $past(mem_rdata);
	endproperty
	a_rdata: assert property (p_rdata) else $error("memory data not passed");
	property p_unbuf;
		!buf_wr_en && mem_req && mem_done && mem_cmd.we |=> cpu_done;
	endproperty
	a_unbuf: assert property (p_unbuf) else $error("write release late");
	property p_pulse;
		cpu_done |=> !cpu_done;
	endproperty
	a_pulse: assert property (p_pulse) else $error("release longer than one cycle");

	c_hit: cover property (cpu_done && cpu_match);
	c_dma: cover property (dma_done);
	c_buf: cover property (buf_wr_en && mem_req && mem_cmd.we && mem_done);
endmodule

bind dmwc_ctl dmwc_ctl_checker CHK (.mclk, .reset_n, .sys_clear, .buf_wr_en, .cpu_done,
	.cpu_match, .cpu_rdata, .dma_done, .mem_req, .mem_cmd, .mem_done, .mem_rdata, .tag_clear);

// ---- testbench/dmwc_ctl_tb.sv ----
// Self-checking bench of the cache controller
`timescale 1ns/1ns
`include "dmwc_params.svh"

module dmwc_ctl_tb
	import dmwc_pkg::*;
;
	logic        mclk = 1'b0;
	logic        reset_n, sys_clear, buf_wr_en, snoop_en, cpu_req, dma_wr;
	logic        cpu_match, cpu_done, dma_done, mem_req, mem_done, tag_clear;
	dmwc_cmd_t   cpu_cmd, dma_cmd, mem_cmd;
	logic [15:0] cpu_rdata, mem_rdata, cdat [int], em [int];
	logic [3:0]  lat;
	logic [23:0] a;
	logic [1:0]  b;
	logic [31:0] r;
	int          ctag [int];
	int          failures, comparisons, seed;
	bit          pend;

	dmwc_ctl DUT (.mclk, .reset_n, .sys_clear, .buf_wr_en, .snoop_en, .cpu_req, .cpu_cmd,
		.cpu_rdata, .cpu_match, .cpu_done, .dma_wr, .dma_cmd, .dma_done, .mem_req, .mem_cmd,
		.mem_done, .mem_rdata, .tag_clear);
	dmwc_mem_model MEM (.mclk, .mem_req, .mem_cmd, .lat, .mem_done, .mem_rdata);

	always #2 mclk = ~mclk;

	task test_done();
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] mrg(input logic [15:0] o, n, input logic [1:0] m);
		mrg = o;
		if (m[0]) mrg[7:0] = n[7:0];
		if (m[1]) mrg[15:8] = n[15:8];
	endfunction

	function automatic logic [15:0] memv(input logic [23:0] x);
		memv = em.exists(x) ? em[x] : x[15:0] ^ 16'h5A3C;
	endfunction

	task op(input logic w, input logic [1:0] m, input logic [23:0] x, input logic [15:0] d);
		int n;
		int i;
		bit f;
		bit h;
		logic [15:0] e;
		i = x[12:0];
		f = x[23:20] == 4'hF || (!snoop_en && x[23:20] == 4'hE);
		h = !f && ctag.exists(i) && ctag[i] == x[23:13];
		e = h ? cdat[i] : memv(x);
		@(negedge mclk);
		cpu_req = 1'b1;
		cpu_cmd = '{w, m, x, d};
		@(negedge mclk);
		cpu_req = 1'b0;
		n = 0;
		while (cpu_done !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 400, 1);
		chk(cpu_match, h);
		if (w) begin
			em[x] = mrg(memv(x), d, m);
			if (!f && m == 2'h3) begin
				ctag[i] = x[23:13];
				cdat[i] = d;
			end else if (h)
				cdat[i] = mrg(cdat[i], d, m);
		end else begin
			chk(cpu_rdata, e);
			if (!h && !f) begin
				ctag[i] = x[23:13];
				cdat[i] = e;
			end
		end
		if (!pend && (w ? buf_wr_en : h)) chk(n, `DMWC_STROBE_CYC);
		if (h && !w) chk(n * `DMWC_CLK_NS <= 100, 1);
		pend = w && buf_wr_en;
	endtask

	task dma(input logic [1:0] m, input logic [23:0] x, input logic [15:0] d);
		int n;
		int i;
		i = x[12:0];
		while (mem_req) @(negedge mclk);
		@(negedge mclk);
		dma_wr = 1'b1;
		dma_cmd = '{1'b1, m, x, d};
		@(negedge mclk);
		dma_wr = 1'b0;
		n = 0;
		while (dma_done !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		chk(n, `DMWC_STROBE_CYC);
		em[x] = mrg(memv(x), d, m);
		MEM.store[x] = em[x];
		pend = 0;
		if (snoop_en && x[23:20] != 4'hF && ctag.exists(i) && ctag[i] == x[23:13])
			cdat[i] = mrg(cdat[i], d, m);
	endtask

	task clr();
		@(negedge mclk);
		sys_clear = 1'b1;
		@(negedge mclk);
		sys_clear = 1'b0;
		repeat (4) @(negedge mclk);
		ctag.delete();
	endtask

	initial begin
		#100000;
		failures++;
		test_done();
	end

	initial begin
		{reset_n, sys_clear, buf_wr_en, cpu_req, dma_wr, pend} = '0;
		{cpu_cmd, dma_cmd} = '0;
		snoop_en = 1'b1;
		lat = 4'h2;
		seed = 32'h9c6756f5;
		repeat (12) @(negedge mclk);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		op(0, 3, 24'h000000, 0);
		op(0, 3, 24'h000000, 0);
		op(0, 3, 24'h002000, 0);
		op(0, 3, 24'h000000, 0);
		op(1, 1, 24'h004001, 16'h1234);
		op(0, 3, 24'h004001, 0);
		op(1, 2, 24'h004001, 16'hABCD);
		op(0, 3, 24'h004001, 0);
		op(1, 3, 24'h006002, 16'h55AA);
		op(0, 3, 24'h006002, 0);
		op(0, 3, 24'hF00003, 0);
		op(1, 3, 24'hF00003, 16'h0F0F);
		op(0, 3, 24'hF00003, 0);
		dma(1, 24'h006002, 16'h00EE);
		op(0, 3, 24'h006002, 0);
		clr();
		op(0, 3, 24'h006002, 0);
		snoop_en = 1'b0;
		op(0, 3, 24'hE00005, 0);
		op(0, 3, 24'hE00005, 0);
		snoop_en = 1'b1;
		for (int p = 0; p < 2; p++) begin
			while (mem_req) @(negedge mclk);
			buf_wr_en = p[0];
			for (int k = 0; k < 90; k++) begin
				r = $random(seed);
				lat = r[15:12];
				a = {r[5] ? 11'h7FF : r[6] ? 11'h700 : {10'h000, r[7]}, {12'h000, r[8]} - r[9]};
				b = r[4:3] == 2'h0 ? 2'h3 : r[4:3];
				if (r[11:10] == 2'h0)
					dma(b, a, r[31:16]);
				else if (r[11:9] == 3'h7)
					clr();
				else
					op(r[0], r[0] ? b : 2'h3, a, r[31:16]);
			end
		end
		repeat (40) @(negedge mclk);
		foreach (em[k]) chk(MEM.store[k], em[k]);
		test_done();
	end
endmodule

// ---- testbench/dmwc_mem_model.sv ----
// Main memory model on the controller's memory port
`timescale 1ns/1ns
`include "dmwc_params.svh"

module dmwc_mem_model
	import dmwc_pkg::*;
(
	input wire logic                    mclk,
	input wire logic                    mem_req,
	input wire dmwc_cmd_t               mem_cmd,
	input wire logic [3:0]              lat,
	output logic                        mem_done,
	output logic [`DMWC_DATA_W-1:0]     mem_rdata
);
	logic [`DMWC_DATA_W-1:0] store [int];
	logic [`DMWC_DATA_W-1:0] v;

	// Read data churns outside answers so a stale word never passes
	initial begin
		mem_done = 1'b0;
		mem_rdata = 16'h0000;
		forever begin
			@(negedge mclk);
			mem_rdata = ~mem_rdata;
			if (mem_req) begin
				repeat (lat) @(negedge mclk);
				v = store.exists(mem_cmd.addr) ? store[mem_cmd.addr] : mem_cmd.addr[15:0] ^ 16'h5A3C;
				if (mem_cmd.we) begin
					if (mem_cmd.be[0]) v[7:0] = mem_cmd.data[7:0];
					if (mem_cmd.be[1]) v[15:8] = mem_cmd.data[15:8];
					store[mem_cmd.addr] = v;
				end else
					mem_rdata = v;
				mem_done = 1'b1;
				@(negedge mclk);
				mem_done = 1'b0;
			end
		end
	end
endmodule
